/* design/jtip_params.svh */
// Constants of the identification and programming test port.
// Functional notes
// - Instruction register is exactly 10 bits, shifted in Shift-IR.
// - Identification and user code registers are both 32 bits long.
// - Boundary register length is a size parameter: 96, 192, 288, 480, 624.
// - Identification word: version 4, part 16, maker 11, then one bit.
// - Identification bit 0 is always one, the first bit shifted out.
// - With security bit set, readback of stored configuration is refused; the user code field stays readable through the user code instruction.
// - Security and configuration bits clear only through an erase.
// - Open-drain pins drive low when active, float when inactive.
// - Per-pin slew bit; unprogrammed means slow edges both ways.
// - During programming all pins float with weak pull-ups on.
// - No pin drives until the programming-complete bit is programmed.
// - Four-signal test port with the standard test state machine.
`ifndef JTIP_PARAMS_SVH
`define JTIP_PARAMS_SVH

`define JTIP_IR_LEN 10
`define JTIP_ID_LEN 32
`define JTIP_BSR_LEN 96
`define JTIP_NPINS 32
`define JTIP_VER_W 4
`define JTIP_PART_W 16
`define JTIP_MANUF_W 11

// Instruction encodings.
`define JTIP_OP_SAMPLE 10'h005
`define JTIP_OP_IDCODE 10'h006
`define JTIP_OP_USER 10'h007
`define JTIP_OP_ERASE 10'h0a0
`define JTIP_OP_PROGRAM 10'h0a1
`define JTIP_OP_VERIFY 10'h0a2
`define JTIP_OP_BYPASS 10'h3ff

// Stored configuration layout.
`define JTIP_CFG_DONE 0
`define JTIP_CFG_SEC 1
`define JTIP_CFG_USER_LSB 2
`define JTIP_CFG_OD_LSB 34

// Budgets the external controller must allow; the port itself times nothing.
`define JTIP_PROGRAM_FIXED_TIME_MS 2000
`define JTIP_PROGRAM_CLOCK_COUNT 55000
`define JTIP_VERIFY_FIXED_TIME_US 2000
`define JTIP_VERIFY_CLOCK_COUNT 18000

`endif

/* design/jtip_pkg.sv */
// Types shared by the test port files.
package jtip_pkg;
  typedef enum logic [3:0] {
    JTIP_TLR, JTIP_RTI, JTIP_SEL_DR, JTIP_CAP_DR, JTIP_SH_DR, JTIP_EX1_DR,
    JTIP_PAU_DR, JTIP_EX2_DR, JTIP_UPD_DR, JTIP_SEL_IR, JTIP_CAP_IR,
    JTIP_SH_IR, JTIP_EX1_IR, JTIP_PAU_IR, JTIP_EX2_IR, JTIP_UPD_IR
  } jtip_tap_t;
endpackage : jtip_pkg

/* design/jtip_tap.sv */
// Test port state machine, stepped on each rising link clock edge.
`timescale 1ns/1ps
module jtip_tap (
  input wire logic clk_sys, // System clock.
  input wire logic rstn, // Asynchronous reset, active low.
  input wire logic step, // One-cycle pulse on a link clock rise.
  input wire logic tms, // Synchronised mode select.
  output jtip_pkg::jtip_tap_t state_q // Current port state.
);
  import jtip_pkg::*;

  jtip_tap_t state_d;

  always_comb begin
    state_d = state_q;
    if (step) begin
      unique case (state_q)
        JTIP_TLR: state_d = tms ? JTIP_TLR : JTIP_RTI;
        JTIP_RTI: state_d = tms ? JTIP_SEL_DR : JTIP_RTI;
        JTIP_SEL_DR: state_d = tms ? JTIP_SEL_IR : JTIP_CAP_DR;
        JTIP_CAP_DR: state_d = tms ? JTIP_EX1_DR : JTIP_SH_DR;
        JTIP_SH_DR: state_d = tms ? JTIP_EX1_DR : JTIP_SH_DR;
        JTIP_EX1_DR: state_d = tms ? JTIP_UPD_DR : JTIP_PAU_DR;
        JTIP_PAU_DR: state_d = tms ? JTIP_EX2_DR : JTIP_PAU_DR;
        JTIP_EX2_DR: state_d = tms ? JTIP_UPD_DR : JTIP_SH_DR;
        JTIP_UPD_DR: state_d = tms ? JTIP_SEL_DR : JTIP_RTI;
        JTIP_SEL_IR: state_d = tms ? JTIP_TLR : JTIP_CAP_IR;
        JTIP_CAP_IR: state_d = tms ? JTIP_EX1_IR : JTIP_SH_IR;
        JTIP_SH_IR: state_d = tms ? JTIP_EX1_IR : JTIP_SH_IR;
        JTIP_EX1_IR: state_d = tms ? JTIP_UPD_IR : JTIP_PAU_IR;
        JTIP_PAU_IR: state_d = tms ? JTIP_EX2_IR : JTIP_PAU_IR;
        JTIP_EX2_IR: state_d = tms ? JTIP_UPD_IR : JTIP_SH_IR;
        JTIP_UPD_IR: state_d = tms ? JTIP_SEL_DR : JTIP_RTI;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_q <= JTIP_TLR;
    end else begin
      state_q <= state_d;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  property p_tlr_exit;
    step && !tms && state_q == JTIP_TLR |=> state_q == JTIP_RTI;
  endproperty
  a_tlr_exit: assert property (p_tlr_exit)
    else $error("Reset state did not move to idle on low mode select.");

endmodule : jtip_tap

/* design/jtip_top.sv */
// Test port with identification, boundary, user code and stored pin options.
`timescale 1ns/1ps
`include "jtip_params.svh"
module jtip_top #(
  parameter int BSR_LEN = `JTIP_BSR_LEN, // Boundary cells of this size.
  parameter int NPINS = `JTIP_NPINS, // User pins; not above BSR_LEN.
  parameter logic [3:0] ID_VERSION = 4'h2, // Arbitrary value.
  parameter logic [15:0] ID_PART = 16'h5a3c, // Arbitrary value.
  parameter logic [10:0] ID_MANUF = 11'h2b1 // Arbitrary value.
) (
  input wire logic clk_sys, // System clock, 100 MHz.
  input wire logic rstn, // Asynchronous reset, blank part at power-on.
  input wire logic tck, // Link clock pin, sampled.
  input wire logic tms, // Mode select pin.
  input wire logic tdi, // Serial data in pin.
  output logic tdo_q, // Serial data out.
  output logic tdo_oe_q, // High while data out is driven.
  input wire logic [NPINS-1:0] core_out, // Array data toward the pins.
  input wire logic [NPINS-1:0] core_oe, // Array output enables.
  input wire logic [NPINS-1:0] pad_in, // Pin levels, asynchronous.
  output logic [NPINS-1:0] pad_out_q, // Pin output level.
  output logic [NPINS-1:0] pad_oe_q, // Pin output enable.
  output logic [NPINS-1:0] pad_pullup_q, // Weak pull-up enable.
  output logic [NPINS-1:0] pad_slow_q, // Slow edge select.
  output logic isp_q, // In-system programming active.
  output logic secure_q // Security bit programmed.
);
  import jtip_pkg::*;

  localparam int IRL = `JTIP_IR_LEN;
  localparam int IDL = `JTIP_ID_LEN;
  localparam int OD_LSB = `JTIP_CFG_OD_LSB;
  localparam int SLEW_LSB = OD_LSB + NPINS;
  localparam int CFG_W = SLEW_LSB + NPINS;

  //////////////////////////////////////////////////////////////////////////////
  // Synchronisers. The third link clock flop exists only for edge finding.
  logic tck_s1, tck_s2, tck_s3, tms_s1, tms_s2, tdi_s1, tdi_s2;
  logic [NPINS-1:0] pin_s1, pin_s2;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      {tck_s1, tck_s2, tck_s3} <= 3'h0;
      {tms_s1, tms_s2, tdi_s1, tdi_s2} <= 4'hf;
      pin_s1 <= '0;
      pin_s2 <= '0;
    end else begin
      {tck_s1, tck_s2, tck_s3} <= {tck, tck_s1, tck_s2};
      {tms_s1, tms_s2, tdi_s1, tdi_s2} <= {tms, tms_s1, tdi, tdi_s1};
      pin_s1 <= pad_in;
      pin_s2 <= pin_s1;
    end
  end

  logic tck_rise, tck_fall;
  assign tck_rise = tck_s2 && !tck_s3;
  assign tck_fall = !tck_s2 && tck_s3;

  jtip_tap_t state;

  jtip_tap u_tap (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .step(tck_rise),
    .tms(tms_s2),
    .state_q(state)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Shift registers and stored configuration.
  logic [IRL-1:0] ir_q, ir_d, irsh_q, irsh_d;
  logic [IDL-1:0] idsh_q, idsh_d, idcode;
  logic [BSR_LEN-1:0] bsr_q, bsr_d;
  logic [CFG_W-1:0] cfgsh_q, cfgsh_d, cfg_q, cfg_d;
  logic byp_q, byp_d;
  logic done, secure, isp_now;

  assign idcode = {ID_VERSION, ID_PART, ID_MANUF, 1'b1};
  assign done = cfg_q[`JTIP_CFG_DONE];
  assign secure = cfg_q[`JTIP_CFG_SEC];
  assign isp_now = state != JTIP_TLR && (ir_q == `JTIP_OP_ERASE ||
    ir_q == `JTIP_OP_PROGRAM || ir_q == `JTIP_OP_VERIFY);

  always_comb begin
    ir_d = ir_q;
    irsh_d = irsh_q;
    idsh_d = idsh_q;
    bsr_d = bsr_q;
    cfgsh_d = cfgsh_q;
    cfg_d = cfg_q;
    byp_d = byp_q;
    if (tck_rise) begin
      unique case (state)
        JTIP_TLR: begin
          ir_d = `JTIP_OP_IDCODE;
        end
        JTIP_CAP_IR: begin
          irsh_d = {{(IRL-2){1'b0}}, 2'h1};
        end
        JTIP_SH_IR: begin
          irsh_d = {tdi_s2, irsh_q[IRL-1:1]};
        end
        JTIP_UPD_IR: begin
          ir_d = irsh_q;
        end
        JTIP_RTI: begin
          // Erase is the only path that clears stored bits.
          if (ir_q == `JTIP_OP_ERASE) begin
            cfg_d = '0;
          end
        end
        JTIP_CAP_DR: begin
          byp_d = 1'b0;
          if (ir_q == `JTIP_OP_IDCODE) begin
            idsh_d = idcode;
          end else if (ir_q == `JTIP_OP_USER) begin
            idsh_d = cfg_q[`JTIP_CFG_USER_LSB +: IDL];
          end else if (ir_q == `JTIP_OP_SAMPLE) begin
            bsr_d = '0;
            bsr_d[NPINS-1:0] = pin_s2;
          end else if (ir_q == `JTIP_OP_VERIFY) begin
            cfgsh_d = secure ? '0 : cfg_q;
          end else if (ir_q == `JTIP_OP_PROGRAM) begin
            cfgsh_d = '0;
          end
        end
        JTIP_SH_DR: begin
          if (ir_q == `JTIP_OP_IDCODE || ir_q == `JTIP_OP_USER) begin
            idsh_d = {tdi_s2, idsh_q[IDL-1:1]};
          end else if (ir_q == `JTIP_OP_SAMPLE) begin
            bsr_d = {tdi_s2, bsr_q[BSR_LEN-1:1]};
          end else if (ir_q == `JTIP_OP_PROGRAM ||
                       ir_q == `JTIP_OP_VERIFY) begin
            cfgsh_d = {tdi_s2, cfgsh_q[CFG_W-1:1]};
          end else begin
            byp_d = tdi_s2;
          end
        end
        JTIP_UPD_DR: begin
          // Programming only sets cells, as in a real erase-before-write array.
          if (ir_q == `JTIP_OP_PROGRAM) begin
            cfg_d = cfg_q | cfgsh_q;
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ir_q <= `JTIP_OP_IDCODE;
      irsh_q <= '0;
      idsh_q <= '0;
      bsr_q <= '0;
      cfgsh_q <= '0;
      cfg_q <= '0;
      byp_q <= 1'b0;
    end else begin
      ir_q <= ir_d;
      irsh_q <= irsh_d;
      idsh_q <= idsh_d;
      bsr_q <= bsr_d;
      cfgsh_q <= cfgsh_d;
      cfg_q <= cfg_d;
      byp_q <= byp_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Serial output, changed on the falling link clock edge.
  logic tdo_d, tdo_oe_d, sel_bit;

  always_comb begin
    if (ir_q == `JTIP_OP_IDCODE || ir_q == `JTIP_OP_USER) begin
      sel_bit = idsh_q[0];
    end else if (ir_q == `JTIP_OP_SAMPLE) begin
      sel_bit = bsr_q[0];
    end else if (ir_q == `JTIP_OP_PROGRAM || ir_q == `JTIP_OP_VERIFY) begin
      sel_bit = cfgsh_q[0];
    end else begin
      sel_bit = byp_q;
    end
    tdo_d = tdo_q;
    tdo_oe_d = tdo_oe_q;
    if (tck_fall) begin
      tdo_oe_d = state == JTIP_SH_IR || state == JTIP_SH_DR;
      tdo_d = state == JTIP_SH_IR ? irsh_q[0] : sel_bit;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      tdo_q <= 1'b0;
      tdo_oe_q <= 1'b0;
    end else begin
      tdo_q <= tdo_d;
      tdo_oe_q <= tdo_oe_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pin control from the stored options.
  logic [NPINS-1:0] od, slew, pout_d, poe_d, ppu_d, pslow_d;

  assign od = cfg_q[OD_LSB +: NPINS];
  assign slew = cfg_q[SLEW_LSB +: NPINS];

  always_comb begin
    pout_d = core_out & ~od;
    poe_d = core_oe & ~(od & core_out);
    if (!done || isp_now) begin
      poe_d = '0;
    end
    ppu_d = {NPINS{isp_now}};
    pslow_d = ~slew;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pad_out_q <= '0;
      pad_oe_q <= '0;
      pad_pullup_q <= '0;
      pad_slow_q <= '1;
      isp_q <= 1'b0;
      secure_q <= 1'b0;
    end else begin
      pad_out_q <= pout_d;
      pad_oe_q <= poe_d;
      pad_pullup_q <= ppu_d;
      pad_slow_q <= pslow_d;
      isp_q <= isp_now;
      secure_q <= secure;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  property p_ir_shift;
    tck_rise && state == JTIP_SH_IR |=>
      irsh_q == {$past(tdi_s2), $past(irsh_q[IRL-1:1])};
  endproperty
  a_ir_shift: assert property (p_ir_shift)
    else $error("Instruction shift did not move ten bits by one.");

  property p_id_capture;
    tck_rise && state == JTIP_CAP_DR && ir_q == `JTIP_OP_IDCODE |=>
      idsh_q == {ID_VERSION, ID_PART, ID_MANUF, 1'b1} && idsh_q[0];
  endproperty
  a_id_capture: assert property (p_id_capture)
    else $error("Identification word not loaded on capture.");

  property p_user_capture;
    tck_rise && state == JTIP_CAP_DR && ir_q == `JTIP_OP_USER |=>
      idsh_q == $past(cfg_q[`JTIP_CFG_USER_LSB +: IDL]);
  endproperty
  a_user_capture: assert property (p_user_capture)
    else $error("User code not loaded on capture.");

  property p_secure_read;
    tck_rise && state == JTIP_CAP_DR && ir_q == `JTIP_OP_VERIFY && secure
      |=> cfgsh_q == '0;
  endproperty
  a_secure_read: assert property (p_secure_read)
    else $error("Secured configuration was read back.");

  property p_no_clear;
    !(tck_rise && state == JTIP_RTI && ir_q == `JTIP_OP_ERASE) |=>
      (cfg_q & $past(cfg_q)) == $past(cfg_q);
  endproperty
  a_no_clear: assert property (p_no_clear)
    else $error("Stored bit cleared without erase.");

  property p_open_drain;
    $stable(od) |-> (pad_out_q & od) == '0 &&
      (pad_oe_q & od & $past(core_out)) == '0;
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("Open-drain pin driven high.");

  property p_slew;
    !slew[0] ##1 !slew[0] |-> pad_slow_q[0];
  endproperty
  a_slew: assert property (p_slew)
    else $error("Unprogrammed slew bit did not select slow edges.");

  property p_isp_float;
    isp_now |=> pad_oe_q == '0 && pad_pullup_q == '1 && isp_q;
  endproperty
  a_isp_float: assert property (p_isp_float)
    else $error("Pin driven or pull-up off during programming.");

  property p_not_done;
    !done |=> pad_oe_q == '0;
  endproperty
  a_not_done: assert property (p_not_done)
    else $error("Pin driven before programming completed.");

endmodule : jtip_top

/* verification/jtip_ctrl_model.sv */
// Model of the external test controller that drives the link pins.
`timescale 1ns/1ps
`include "jtip_params.svh"
module jtip_ctrl_model #(
  // Idle clocks after a program pass.
  parameter int PROG_CLOCKS = `JTIP_PROGRAM_CLOCK_COUNT,
  // Fixed program wait in ns.
  parameter realtime PROG_FIXED_NS = `JTIP_PROGRAM_FIXED_TIME_MS * 1.0e6,
  // Idle clocks after a verify pass.
  parameter int VERIFY_CLOCKS = `JTIP_VERIFY_CLOCK_COUNT,
  // Fixed verify wait in ns.
  parameter realtime VERIFY_FIXED_NS = `JTIP_VERIFY_FIXED_TIME_US * 1.0e3
) (
  output logic tck, // Link clock, low between frames.
  output logic tms, // Mode select.
  output logic tdi, // Serial data toward the device.
  input wire logic tdo // Serial data from the device.
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end

  // Device data is taken just before the rise, after it settled on the fall.
  task automatic bit_cyc(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #62.5;
    q = tdo;
    tck = 1'b1;
    #62.5;
    tck = 1'b0;
  endtask : bit_cyc

  task automatic go_idle();
    logic q;
    for (int i = 0; i < 5; i++) begin
      bit_cyc(1'b1, ~tdi, q);
    end
    bit_cyc(1'b0, ~tdi, q);
  endtask : go_idle

  // From Run-Test/Idle through a full scan back to Run-Test/Idle.
  task automatic shift(input logic ir, input logic [127:0] din,
                       input int len, output logic [127:0] dout);
    logic q;
    dout = '0;
    bit_cyc(1'b1, ~tdi, q);
    if (ir) begin
      bit_cyc(1'b1, ~tdi, q);
    end
    bit_cyc(1'b0, ~tdi, q);
    bit_cyc(1'b0, ~tdi, q);
    for (int i = 0; i < len; i++) begin
      bit_cyc(i == len - 1, din[i], q);
      dout[i] = q;
    end
    bit_cyc(1'b1, ~tdi, q);
    bit_cyc(1'b0, ~tdi, q);
  endtask : shift

  // The clock stands still through the fixed part of each budget.
  task automatic idle(input int n);
    logic q;
    for (int i = 0; i < n; i++) begin
      bit_cyc(1'b0, ~tdi, q);
    end
  endtask : idle

  task automatic prog_wait();
    #(PROG_FIXED_NS);
    idle(PROG_CLOCKS);
  endtask : prog_wait

  task automatic verify_wait();
    #(VERIFY_FIXED_NS);
    idle(VERIFY_CLOCKS);
  endtask : verify_wait
endmodule : jtip_ctrl_model

/* verification/jtip_top_tb.sv */
// Self-checking bench for the test port, driven through the controller model.
`timescale 1ns/1ps
`include "jtip_params.svh"
module jtip_top_tb;
  localparam int NP = 8;
  localparam int CFG_W = `JTIP_CFG_OD_LSB + 2 * NP;
  localparam logic [3:0] VER = 4'h9; // Arbitrary value.
  localparam logic [15:0] PART = 16'hc1e7; // Arbitrary value.
  localparam logic [10:0] MAN = 11'h35d; // Arbitrary value.
  localparam logic [NP-1:0] OD = 8'h3c;
  localparam logic [NP-1:0] SLEW = 8'h0f;
  localparam logic [CFG_W-1:0] CFG = {SLEW, OD, 32'h1234abcd, 2'b01};
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic tck, tms, tdi, tdo_q, tdo_oe_q, isp_q, secure_q;
  logic [NP-1:0] core_out = '0;
  logic [NP-1:0] core_oe = '0;
  logic [NP-1:0] pad_in = '0;
  logic [NP-1:0] pad_out_q, pad_oe_q, pad_pullup_q, pad_slow_q;
  logic [127:0] got;
  int fails = 0;
  int checks = 0;

  always #5 clk_sys = ~clk_sys;

  jtip_top #(.BSR_LEN(96), .NPINS(NP), .ID_VERSION(VER), .ID_PART(PART),
    .ID_MANUF(MAN)) dut (.clk_sys(clk_sys), .rstn(rstn), .tck(tck),
    .tms(tms), .tdi(tdi), .tdo_q(tdo_q), .tdo_oe_q(tdo_oe_q),
    .core_out(core_out), .core_oe(core_oe), .pad_in(pad_in),
    .pad_out_q(pad_out_q), .pad_oe_q(pad_oe_q),
    .pad_pullup_q(pad_pullup_q), .pad_slow_q(pad_slow_q), .isp_q(isp_q),
    .secure_q(secure_q));

  // Budgets are cut short so the run stays brief; the port times nothing.
  // A released data line floats high through its pull-up.
  jtip_ctrl_model #(.PROG_CLOCKS(20), .PROG_FIXED_NS(200.0),
    .VERIFY_CLOCKS(12), .VERIFY_FIXED_NS(100.0)) ctl (.tck(tck),
    .tms(tms), .tdi(tdi), .tdo(tdo_oe_q ? tdo_q : 1'b1));

  task automatic check(input string what, input logic [127:0] seen,
                       input logic [127:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic complete_run();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run

  task automatic set_ir(input logic [9:0] op);
    ctl.shift(1'b1, {108'h0, op, 10'h2b5}, 20, got);
    check("ir_capture", got[9:0], 10'h001);
    check("ir_len", got[19:10], 10'h2b5);
  endtask : set_ir

  // A marker shifted in behind the register shows its exact length.
  task automatic dr_len(input string what, input int len,
                        input logic [127:0] exp);
    ctl.shift(1'b0, 128'h96, len + 8, got);
    check(what, got & ((128'h1 << len) - 1), exp);
    check(what, (got >> len) & 128'hff, 128'h96);
  endtask : dr_len

  initial begin
    repeat (8) @(negedge clk_sys);
    check("tdo_oe", tdo_oe_q, 0);
    rstn = 1'b1;
    repeat (4) @(negedge clk_sys);
    core_oe = '1;
    core_out = 8'h55;
    pad_in = 8'ha6;
    ctl.go_idle();
    check("pad_oe_blank", pad_oe_q, 0);
    check("pad_slow_blank", pad_slow_q, {NP{1'b1}});
    check("secure_blank", secure_q, 0);
    dr_len("idcode", 32, {VER, PART, MAN, 1'b1});
    set_ir(`JTIP_OP_USER);
    dr_len("user_blank", 32, 0);
    set_ir(`JTIP_OP_SAMPLE);
    ctl.shift(1'b0, 128'h96, 104, got);
    check("bsr_len", got[103:96], 8'h96);
    check("bsr_pins", got[95:0], 96'ha6);
    set_ir(10'h155);
    dr_len("bypass", 1, 0);
    set_ir(`JTIP_OP_PROGRAM);
    check("isp", isp_q, 1);
    check("pullup", pad_pullup_q, {NP{1'b1}});
    check("pad_oe_isp", pad_oe_q, 0);
    ctl.shift(1'b0, 128'(CFG), CFG_W, got);
    ctl.prog_wait();
    set_ir(`JTIP_OP_USER);
    check("isp_off", isp_q, 0);
    dr_len("user_prog", 32, 32'h1234abcd);
    check("pad_oe", pad_oe_q, NP'(core_oe & ~(OD & core_out)));
    check("pad_out", pad_out_q, NP'(core_out & ~OD));
    check("pad_slow", pad_slow_q, NP'(~SLEW));
    set_ir(`JTIP_OP_VERIFY);
    ctl.shift(1'b0, 128'h0, CFG_W, got);
    check("readback", got, 128'(CFG));
    ctl.verify_wait();
    set_ir(`JTIP_OP_PROGRAM);
    ctl.shift(1'b0, 128'h2, CFG_W, got);
    ctl.prog_wait();
    set_ir(`JTIP_OP_VERIFY);
    check("secure_set", secure_q, 1);
    ctl.shift(1'b0, 128'h0, CFG_W, got);
    check("readback_secure", got, 0);
    ctl.go_idle();
    dr_len("idcode_tlr", 32, {VER, PART, MAN, 1'b1});
    set_ir(`JTIP_OP_PROGRAM);
    ctl.shift(1'b0, 128'h0, CFG_W, got);
    set_ir(`JTIP_OP_USER);
    check("secure_kept", secure_q, 1);
    dr_len("user_kept", 32, 32'h1234abcd);
    set_ir(`JTIP_OP_ERASE);
    ctl.idle(4);
    repeat (4) @(negedge clk_sys);
    check("secure_erased", secure_q, 0);
    set_ir(`JTIP_OP_USER);
    dr_len("user_erased", 32, 0);
    complete_run();
  end

  initial begin
    #500_000;
    fails++;
    complete_run();
  end
endmodule : jtip_top_tb
